// [usrw_ctrl.sv]
// How it works
// - The new bus address is used from the first transaction that starts after firmware sets the address enable bit.
// - Suspend is entered only after the bus has been idle without a break for at least 3 ms.
// - Suspend detection sets the global suspend flag and raises the interrupt when it is enabled.
// - When the microcontroller sleeps during suspend, oscillator and PLL are switched off.
// - Non-idle bus signalling or an enabled external interrupt ends suspend.
// - Resume signalling from the function itself is started only when remote wakeup is enabled.
// - An edge on an external interrupt input whose wake enable bit is set, during suspend, restarts oscillator, PLL and USB logic.
// - A remote wakeup drives resume signalling upstream.
// - Firmware clears the suspend flags by writing ones; a set in the same cycle wins.
// - Bit 2 of the overcurrent detect enable register selects the port D bit 0 pin as wake trigger.
// - With that bit and remote wakeup enabled, a low port D bit 0 pin during suspend starts a resume.
// - Host resume signalling restarts the oscillator and sets the resume flag.
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module usrw_ctrl
#(
  parameter int IDLE_CYCLES   = usrw_pkg::IDLE_CYCLES,
  parameter int RESUME_CYCLES = usrw_pkg::RESUME_CYCLES
)
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        BUS_IDLE_IN,
  input  wire logic        TRANSACTION_START_IN,
  input  wire logic        MCU_SLEEP_IN,
  input  wire logic        EXT_IRQ_ZERO_IN,
  input  wire logic        EXT_IRQ_ONE_IN,
  input  wire logic        PORT_D_BIT_ZERO_IN,
  output logic [6:0]       ACTIVE_ADDR_OUT,
  output logic             OSC_EN_OUT,
  output logic             PLL_EN_OUT,
  output logic             USB_LOGIC_EN_OUT,
  output logic             RESUME_DRIVE_OUT,
  output logic             SUSPENDED_OUT,
  output logic             IRQ_OUT
);

  if (IDLE_CYCLES < 1 || RESUME_CYCLES < 1)
  begin : g_bad_counts
    $error("Timer counts must be at least one");
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  usrw_pkg::usrw_state_e state;
  usrw_pkg::usrw_state_e next_state;
  logic                  hub_address_enable;
  logic [6:0]            new_addr;
  logic [2:0]            suspend_resume_status;
  logic [2:0]            next_status;
  logic [2:0]            irq_en;
  logic [2:0]            wake_cfg;
  logic [7:0]            overcurrent_detect_enable;
  logic                  wr_pend;
  logic [7:0]            wr_ofs;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       addr_phase = HSEL_IN && HREADY_IN && (HTRANS_IN == usrw_pkg::HTRANS_NSQ);
  wire [7:0] a_ofs      = HADDR_IN[usrw_pkg::OFS_W-1:0];
  wire       wr_ctrl    = wr_pend && (wr_ofs == usrw_pkg::OFS_CTRL);
  wire       wr_addr    = wr_pend && (wr_ofs == usrw_pkg::OFS_ADDR);
  wire       wr_status  = wr_pend && (wr_ofs == usrw_pkg::OFS_STATUS);
  wire       wr_irqen   = wr_pend && (wr_ofs == usrw_pkg::OFS_IRQEN);
  wire       wr_wake    = wr_pend && (wr_ofs == usrw_pkg::OFS_WAKE);
  wire       wr_ocde    = wr_pend && (wr_ofs == usrw_pkg::OFS_OCDE);
  wire [2:0] clr_mask   = wr_status ? HWDATA_IN[usrw_pkg::FLAG_W-1:0] : usrw_pkg::FLAG_RST;

  wire [31:0] rd_ctrl   = {31'h0000_0000, hub_address_enable};
  wire [31:0] rd_addr   = {25'h000_0000, new_addr};
  wire [31:0] rd_status = {29'h0000_0000, suspend_resume_status};
  wire [31:0] rd_irqen  = {29'h0000_0000, irq_en};
  wire [31:0] rd_wake   = {29'h0000_0000, wake_cfg};
  wire [31:0] rd_ocde   = {24'h00_0000, overcurrent_detect_enable};
  wire [31:0] rd_power  = {26'h000_0000, state, RESUME_DRIVE_OUT, PLL_EN_OUT, OSC_EN_OUT, IRQ_OUT};
  wire [31:0] rd_word   = (a_ofs == usrw_pkg::OFS_CTRL)   ? rd_ctrl   :
                          (a_ofs == usrw_pkg::OFS_ADDR)   ? rd_addr   :
                          (a_ofs == usrw_pkg::OFS_STATUS) ? rd_status :
                          (a_ofs == usrw_pkg::OFS_IRQEN)  ? rd_irqen  :
                          (a_ofs == usrw_pkg::OFS_WAKE)   ? rd_wake   :
                          (a_ofs == usrw_pkg::OFS_OCDE)   ? rd_ocde   :
                          (a_ofs == usrw_pkg::OFS_POWER)  ? rd_power  : usrw_pkg::WORD_ZERO;

  // ----------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------
  logic [1:0] irq_edge;

  usrw_edge #(.WIDTH(2)) u_irq_edge
  (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RST_N_IN),
    .sig_in   ({EXT_IRQ_ONE_IN, EXT_IRQ_ZERO_IN}),
    .edge_out (irq_edge)
  );

  wire in_suspend  = (state == usrw_pkg::ST_SUSPEND) || (state == usrw_pkg::ST_POWERDOWN);
  wire bus_active  = !BUS_IDLE_IN;
  wire irq_wake    = (irq_edge[0] && wake_cfg[usrw_pkg::BIT_IRQ0_EN])
                  || (irq_edge[1] && wake_cfg[usrw_pkg::BIT_IRQ1_EN]);
  wire pd0_wake    = !PORT_D_BIT_ZERO_IN
                  && overcurrent_detect_enable[usrw_pkg::BIT_PD0_WAKE];
  wire ext_wake    = in_suspend && (irq_wake || pd0_wake);
  wire host_resume = in_suspend && bus_active;
  wire remote_req  = ext_wake && wake_cfg[usrw_pkg::BIT_REMOTE_EN];

  // ----------------------------------------------------------------
  // Idle and resume timers
  // ----------------------------------------------------------------
  logic idle_done;
  logic drive_done;

  usrw_timer #(.CYCLES(IDLE_CYCLES)) u_idle
  (
    .clk_in     (CLK_SYS_IN),
    .rst_n_in   (RST_N_IN),
    .run_in     (state == usrw_pkg::ST_ACTIVE),
    .restart_in (bus_active),
    .done_out   (idle_done)
  );

  usrw_timer #(.CYCLES(RESUME_CYCLES)) u_drive
  (
    .clk_in     (CLK_SYS_IN),
    .rst_n_in   (RST_N_IN),
    .run_in     (state == usrw_pkg::ST_RESUME),
    .restart_in (1'b0),
    .done_out   (drive_done)
  );

  wire suspend_detect = (state == usrw_pkg::ST_ACTIVE) && idle_done && !bus_active;
  wire wake_done      = (state == usrw_pkg::ST_RESUME) && drive_done;

  // ----------------------------------------------------------------
  // Suspend state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      usrw_pkg::ST_ACTIVE:
      begin
        if (suspend_detect) next_state = usrw_pkg::ST_SUSPEND;
      end
      usrw_pkg::ST_SUSPEND, usrw_pkg::ST_POWERDOWN:
      begin
        if (host_resume) next_state = usrw_pkg::ST_ACTIVE;
        else if (remote_req) next_state = usrw_pkg::ST_RESUME;
        else if (ext_wake) next_state = usrw_pkg::ST_ACTIVE;
        else if (MCU_SLEEP_IN) next_state = usrw_pkg::ST_POWERDOWN;
      end
      usrw_pkg::ST_RESUME:
      begin
        if (drive_done) next_state = usrw_pkg::ST_ACTIVE;
      end
    endcase
  end

  // Set beats a clear in the same cycle
  assign next_status[usrw_pkg::BIT_SUSP] = suspend_detect
    || (suspend_resume_status[usrw_pkg::BIT_SUSP] && !clr_mask[usrw_pkg::BIT_SUSP]);
  assign next_status[usrw_pkg::BIT_RESUME] = host_resume || wake_done
    || (suspend_resume_status[usrw_pkg::BIT_RESUME] && !clr_mask[usrw_pkg::BIT_RESUME]);
  assign next_status[usrw_pkg::BIT_RWAKE] = wake_done
    || (suspend_resume_status[usrw_pkg::BIT_RWAKE] && !clr_mask[usrw_pkg::BIT_RWAKE]);

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state                 <= usrw_pkg::ST_ACTIVE;
      suspend_resume_status <= usrw_pkg::FLAG_RST;
      OSC_EN_OUT            <= 1'b1;
      PLL_EN_OUT            <= 1'b1;
      USB_LOGIC_EN_OUT      <= 1'b1;
      RESUME_DRIVE_OUT      <= 1'b0;
      SUSPENDED_OUT         <= 1'b0;
      IRQ_OUT               <= 1'b0;
    end
    else
    begin
      state                 <= next_state;
      suspend_resume_status <= next_status;
      OSC_EN_OUT            <= next_state != usrw_pkg::ST_POWERDOWN;
      PLL_EN_OUT            <= next_state != usrw_pkg::ST_POWERDOWN;
      USB_LOGIC_EN_OUT      <= next_state != usrw_pkg::ST_POWERDOWN;
      RESUME_DRIVE_OUT      <= next_state == usrw_pkg::ST_RESUME;
      SUSPENDED_OUT         <= next_state != usrw_pkg::ST_ACTIVE;
      IRQ_OUT               <= |(next_status & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // Register file and bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      wr_pend                   <= 1'b0;
      wr_ofs                    <= usrw_pkg::OFS_CTRL;
      HRDATA_OUT                <= usrw_pkg::WORD_ZERO;
      HREADYOUT_OUT             <= 1'b1;
      HRESP_OUT                 <= usrw_pkg::HRESP_OKAY;
      hub_address_enable        <= 1'b0;
      new_addr                  <= usrw_pkg::ADDR_RST;
      irq_en                    <= usrw_pkg::FLAG_RST;
      wake_cfg                  <= usrw_pkg::FLAG_RST;
      overcurrent_detect_enable <= usrw_pkg::OCDE_RST;
    end
    else
    begin
      wr_pend <= addr_phase && HWRITE_IN;
      wr_ofs  <= a_ofs;
      if (addr_phase && !HWRITE_IN) HRDATA_OUT <= rd_word;
      if (wr_ctrl) hub_address_enable <= HWDATA_IN[usrw_pkg::BIT_HUB_ADDRESS_ENABLE];
      if (wr_addr) new_addr <= HWDATA_IN[usrw_pkg::ADDR_W-1:0];
      if (wr_irqen) irq_en <= HWDATA_IN[usrw_pkg::FLAG_W-1:0];
      if (wr_wake) wake_cfg <= HWDATA_IN[usrw_pkg::FLAG_W-1:0];
      if (wr_ocde) overcurrent_detect_enable <= HWDATA_IN[usrw_pkg::OCDE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Address commit
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ACTIVE_ADDR_OUT <= usrw_pkg::ADDR_RST;
    end
    else if (TRANSACTION_START_IN)
    begin
      ACTIVE_ADDR_OUT <= hub_address_enable ? new_addr : usrw_pkg::ADDR_RST;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int idle_seen;

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN) idle_seen <= 0;
    else if (bus_active) idle_seen <= 0;
    else idle_seen <= idle_seen + 1;
  end

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_N_IN);

  a_addr_commit_next: assert property (
    TRANSACTION_START_IN && hub_address_enable |=> ACTIVE_ADDR_OUT == $past(new_addr))
    else $error("New address not used at transaction start");

  a_suspend_idle_min: assert property (
    suspend_detect |-> idle_seen >= IDLE_CYCLES)
    else $error("Suspend entered before the idle time");

  a_suspend_flag_irq: assert property (
    suspend_detect && irq_en[usrw_pkg::BIT_SUSP]
      |=> suspend_resume_status[usrw_pkg::BIT_SUSP] && IRQ_OUT)
    else $error("Suspend flag or interrupt missing");

  a_sleep_clocks_off: assert property (
    state == usrw_pkg::ST_SUSPEND && MCU_SLEEP_IN && !host_resume && !ext_wake
      |=> !OSC_EN_OUT && !PLL_EN_OUT && !USB_LOGIC_EN_OUT)
    else $error("Clocks not stopped in sleep");

  a_host_resume_wake: assert property (
    host_resume |=> OSC_EN_OUT && suspend_resume_status[usrw_pkg::BIT_RESUME]
      && state == usrw_pkg::ST_ACTIVE)
    else $error("Host resume not handled");

  a_remote_gated_en: assert property (
    in_suspend && !wake_cfg[usrw_pkg::BIT_REMOTE_EN] |=> !RESUME_DRIVE_OUT)
    else $error("Resume driven without remote wakeup enabled");

  a_irq_edge_restart: assert property (
    state == usrw_pkg::ST_POWERDOWN && irq_wake |=> OSC_EN_OUT && PLL_EN_OUT && USB_LOGIC_EN_OUT)
    else $error("External edge did not restart clocks");

  a_remote_drive_up: assert property (
    remote_req && !host_resume |=> RESUME_DRIVE_OUT && OSC_EN_OUT)
    else $error("Remote wakeup did not drive resume");

  a_wake_flags_set: assert property (
    wake_done |=> suspend_resume_status[usrw_pkg::BIT_RWAKE]
      && suspend_resume_status[usrw_pkg::BIT_RESUME] && !RESUME_DRIVE_OUT)
    else $error("Wake flags not set after remote wakeup");

  a_set_beats_clear: assert property (
    suspend_detect && clr_mask[usrw_pkg::BIT_SUSP] |=> suspend_resume_status[usrw_pkg::BIT_SUSP])
    else $error("Flag clear won over set");

  a_pd0_low_wake: assert property (
    in_suspend && pd0_wake && wake_cfg[usrw_pkg::BIT_REMOTE_EN] && !host_resume
      |=> state == usrw_pkg::ST_RESUME)
    else $error("Port D low did not start resume");

  a_activity_restart: assert property (
    state == usrw_pkg::ST_ACTIVE && bus_active |=> !idle_done)
    else $error("Idle timer not restarted by activity");

  a_addr_default: assert property (
    TRANSACTION_START_IN && !hub_address_enable |=> ACTIVE_ADDR_OUT == usrw_pkg::ADDR_RST)
    else $error("Default address not used while enable is clear");

  a_plain_ext_wake: assert property (
    ext_wake && !remote_req && !host_resume |=> state == usrw_pkg::ST_ACTIVE && OSC_EN_OUT)
    else $error("Enabled external interrupt did not end suspend");

  a_pd0_gated_off: assert property (
    in_suspend && !overcurrent_detect_enable[usrw_pkg::BIT_PD0_WAKE]
      && !irq_wake && !bus_active |=> SUSPENDED_OUT && !RESUME_DRIVE_OUT)
    else $error("Port D wake acted while disabled");

  c_suspend_seen: cover property (suspend_detect);
  c_host_resume: cover property (host_resume ##1 state == usrw_pkg::ST_ACTIVE);
  c_remote_wake: cover property (wake_done);
  c_powerdown: cover property (state == usrw_pkg::ST_POWERDOWN);
  c_set_wins: cover property (suspend_detect && clr_mask[usrw_pkg::BIT_SUSP]);

endmodule : usrw_ctrl

// [usrw_ctrl_tb.sv]
`timescale 1ns/1ps
module usrw_ctrl_tb;
  localparam int IDLE = 20;
  localparam int RSMC = 8;
  logic        clk_sys;
  logic        rst_n;
  logic [1:0]  htrans;
  logic        hsel;
  logic        sel_on;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        bus_idle, txn, sleep, irq0, irq1, pd0;
  logic [6:0]  act_addr;
  logic        osc_en, pll_en, usb_en, rsm_drv, susp, irq;
  int          num_errors;
  int          total_checks;
  int          n;
  logic [31:0] rd;

  typedef struct {logic [7:0] ofs; logic [31:0] wr; logic [31:0] exp;} usrw_row_s;
  usrw_row_s rows [8] = '{
    '{usrw_pkg::OFS_STATUS, 32'h0000_00ff, 32'h0000_0000},
    '{usrw_pkg::OFS_CTRL,   32'h0000_0001, 32'h0000_0001},
    '{usrw_pkg::OFS_ADDR,   32'h0000_00ff, 32'h0000_007f},
    '{usrw_pkg::OFS_IRQEN,  32'h0000_00ff, 32'h0000_0007},
    '{usrw_pkg::OFS_WAKE,   32'h0000_00ff, 32'h0000_0007},
    '{usrw_pkg::OFS_OCDE,   32'h0000_00ff, 32'h0000_00ff},
    '{usrw_pkg::OFS_POWER,  32'h0000_00ff, 32'h0000_0006},
    '{8'h40,                32'h0000_ffff, 32'h0000_0000}};

  usrw_ctrl #(.IDLE_CYCLES(IDLE), .RESUME_CYCLES(RSMC)) i_dut
  (
    .CLK_SYS_IN           (clk_sys),
    .RST_N_IN             (rst_n),
    .HSEL_IN              (hsel),
    .HADDR_IN             (haddr),
    .HTRANS_IN            (htrans),
    .HWRITE_IN            (hwrite),
    .HSIZE_IN             (hsize),
    .HWDATA_IN            (hwdata),
    .HREADY_IN            (hready),
    .HRDATA_OUT           (hrdata),
    .HREADYOUT_OUT        (hready),
    .HRESP_OUT            (hresp),
    .BUS_IDLE_IN          (bus_idle),
    .TRANSACTION_START_IN (txn),
    .MCU_SLEEP_IN         (sleep),
    .EXT_IRQ_ZERO_IN      (irq0),
    .EXT_IRQ_ONE_IN       (irq1),
    .PORT_D_BIT_ZERO_IN   (pd0),
    .ACTIVE_ADDR_OUT      (act_addr),
    .OSC_EN_OUT           (osc_en),
    .PLL_EN_OUT           (pll_en),
    .USB_LOGIC_EN_OUT     (usb_en),
    .RESUME_DRIVE_OUT     (rsm_drv),
    .SUSPENDED_OUT        (susp),
    .IRQ_OUT              (irq)
  );

  usrw_far_model i_far
  (
    .clk_in       (clk_sys),
    .bus_idle_out (bus_idle),
    .txn_out      (txn),
    .sleep_out    (sleep),
    .irq0_out     (irq0),
    .irq1_out     (irq1),
    .pd0_out      (pd0)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------
  // Helpers
  // ----------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic give_up();
    num_errors++;
    $display("[FAIL] t=%0t wait bound used up", $time);
    close_out();
  endtask : give_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk_sys);
    while (hready !== 1'b1)
    begin
      k++;
      if (k > 20) give_up();
      @(posedge clk_sys);
    end
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    htrans <= usrw_pkg::HTRANS_NSQ;
    hsel   <= sel_on;
    hsize  <= 3'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  function automatic logic pick(input int w);
    case (w)
      0: return susp;
      1: return rsm_drv;
      default: return osc_en;
    endcase
  endfunction : pick

  task automatic wait_on(input int w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v)
    begin
      n++;
      if (n > lim) give_up();
      tick(1);
    end
  endtask : wait_on

  task automatic go_sleep();
    i_far.set_idle(1'b1);
    wait_on(0, 1'b1, IDLE + 8);
    i_far.sleep(1'b1);
    tick(2);
    check(32'({osc_en, pll_en, usb_en}), 32'h0);
  endtask : go_sleep

  // ----------
  // Sequence
  // ----------
  initial
  begin
    rst_n = 1'b0;
    htrans = 2'h0;
    hsel = 1'b0;
    sel_on = 1'b1;
    hsize = 3'h2;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    check(32'({act_addr, osc_en, pll_en, usb_en, rsm_drv, susp, irq, hready, hresp}), 32'h0000_00e2);
    $display("test reset done");
    foreach (rows[i])
    begin
      xfer(1'b1, rows[i].ofs, rows[i].wr);
      xfer(1'b0, rows[i].ofs, 32'h0);
      check(rd, rows[i].exp);
    end
    $display("test registers done");
    check(32'(act_addr), 32'h0);
    i_far.txn();
    tick(1);
    check(32'(act_addr), 32'h0000_007f);
    xfer(1'b1, usrw_pkg::OFS_CTRL, 32'h0);
    i_far.txn();
    tick(1);
    check(32'(act_addr), 32'h0);
    $display("test address done");
    sel_on = 1'b0;
    xfer(1'b1, usrw_pkg::OFS_ADDR, 32'h0000_0055);
    sel_on = 1'b1;
    xfer(1'b0, usrw_pkg::OFS_ADDR, 32'h0);
    check(rd, 32'h0000_007f);
    $display("test deselect done");
    i_far.set_idle(1'b1);
    tick(IDLE - 4);
    i_far.set_idle(1'b0);
    i_far.set_idle(1'b1);
    tick(IDLE - 4);
    check(32'(susp), 32'h0);
    tick(2);
    xfer(1'b1, usrw_pkg::OFS_STATUS, 32'h0000_0007);
    wait_on(0, 1'b1, 8);
    check(32'(irq), 32'h1);
    xfer(1'b0, usrw_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0000_0001);
    i_far.sleep(1'b1);
    tick(2);
    check(32'({osc_en, pll_en, usb_en}), 32'h0);
    i_far.set_idle(1'b0);
    tick(2);
    check(32'({susp, osc_en, pll_en, usb_en}), 32'h0000_0007);
    xfer(1'b0, usrw_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0000_0003);
    xfer(1'b1, usrw_pkg::OFS_STATUS, 32'h0000_0007);
    xfer(1'b0, usrw_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    tick(1);
    check(32'(irq), 32'h0);
    i_far.sleep(1'b0);
    $display("test host resume done");
    for (int s = 0; s < 3; s++)
    begin
      go_sleep();
      i_far.wake(s);
      wait_on(1, 1'b1, 6);
      wait_on(1, 1'b0, RSMC + 4);
      check(32'(n >= RSMC - 1 && n <= RSMC + 1), 32'h1);
      i_far.set_idle(1'b0);
      i_far.pd_release();
      tick(1);
      check(32'({osc_en, pll_en, usb_en, susp}), 32'h0000_000e);
      xfer(1'b0, usrw_pkg::OFS_STATUS, 32'h0);
      check(rd, 32'h0000_0007);
      xfer(1'b1, usrw_pkg::OFS_STATUS, 32'h0000_0007);
      i_far.sleep(1'b0);
    end
    xfer(1'b1, usrw_pkg::OFS_OCDE, 32'h0000_00fb);
    $display("test remote wakeup done");
    xfer(1'b1, usrw_pkg::OFS_WAKE, 32'h0000_0006);
    go_sleep();
    i_far.wake(0);
    wait_on(2, 1'b1, 8);
    tick(2);
    check(32'({rsm_drv, susp}), 32'h0);
    xfer(1'b0, usrw_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0000_0001);
    xfer(1'b1, usrw_pkg::OFS_STATUS, 32'h0000_0007);
    i_far.set_idle(1'b0);
    i_far.sleep(1'b0);
    xfer(1'b1, usrw_pkg::OFS_WAKE, 32'h0);
    go_sleep();
    i_far.wake(1);
    i_far.wake(2);
    tick(6);
    check(32'({osc_en, susp}), 32'h0000_0001);
    i_far.set_idle(1'b0);
    wait_on(2, 1'b1, 8);
    i_far.pd_release();
    i_far.sleep(1'b0);
    $display("test wake sources done");
    go_sleep();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    check(32'({act_addr, osc_en, pll_en, usb_en, rsm_drv, susp, irq, hready, hresp}), 32'h0000_00e2);
    xfer(1'b0, usrw_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : usrw_ctrl_tb

// [usrw_edge.sv]
`timescale 1ns/1ps
module usrw_edge
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] sig_in,
  output logic      [WIDTH-1:0] edge_out
);

  if (WIDTH < 1)
  begin : g_bad_width
    $error("WIDTH must be at least one");
  end

  logic [WIDTH-1:0] prev;
  logic             primed;

  // First sample only primes, so a high level at reset is no edge
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev   <= '0;
      primed <= 1'b0;
    end
    else
    begin
      prev   <= sig_in;
      primed <= 1'b1;
    end
  end

  assign edge_out = primed ? (sig_in ^ prev) : '0;

endmodule : usrw_edge

// [usrw_far_model.sv]
`timescale 1ns/1ps
// ----------
// Host and firmware side
// ----------
module usrw_far_model
(
  input  wire logic clk_in,
  output logic      bus_idle_out,
  output logic      txn_out,
  output logic      sleep_out,
  output logic      irq0_out,
  output logic      irq1_out,
  output logic      pd0_out
);
  initial
  begin
    bus_idle_out = 1'b0;
    txn_out      = 1'b0;
    sleep_out    = 1'b0;
    irq0_out     = 1'b0;
    irq1_out     = 1'b0;
    pd0_out      = 1'b1;
  end

  task automatic set_idle(input logic v);
    @(posedge clk_in);
    bus_idle_out <= v;
  endtask : set_idle

  task automatic txn();
    @(posedge clk_in);
    txn_out <= 1'b1;
    @(posedge clk_in);
    txn_out <= 1'b0;
  endtask : txn

  task automatic sleep(input logic v);
    // Peripherals quiet, sleep bits set, then sleep executed
    @(posedge clk_in);
    sleep_out <= v;
  endtask : sleep

  task automatic wake(input int src);
    @(posedge clk_in);
    case (src)
      0: irq0_out <= ~irq0_out;
      1: irq1_out <= ~irq1_out;
      default: pd0_out <= 1'b0;
    endcase
  endtask : wake

  task automatic pd_release();
    @(posedge clk_in);
    pd0_out <= 1'b1;
  endtask : pd_release
endmodule : usrw_far_model

// [usrw_pkg.sv]
package usrw_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int IDLE_MIN_US     = 3000;
  localparam int IDLE_CYCLES     = (IDLE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_DRIVE_US = 10000;
  localparam int RESUME_CYCLES   = (RESUME_DRIVE_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Bus
  // ----------------------------------------------------------------
  localparam int           DATA_W     = 32;
  localparam int           OFS_W      = 8;
  localparam int           ADDR_W     = 7;
  localparam logic [1:0]   HTRANS_NSQ = 2'h2;
  localparam logic         HRESP_OKAY = 1'b0;
  localparam logic [31:0]  WORD_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQEN  = 8'h0C;
  localparam logic [7:0] OFS_WAKE   = 8'h10;
  localparam logic [7:0] OFS_OCDE   = 8'h14;
  localparam logic [7:0] OFS_POWER  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_HUB_ADDRESS_ENABLE    = 0;
  localparam int BIT_SUSP       = 0;
  localparam int BIT_RESUME     = 1;
  localparam int BIT_RWAKE      = 2;
  localparam int BIT_REMOTE_EN  = 0;
  localparam int BIT_IRQ0_EN    = 1;
  localparam int BIT_IRQ1_EN    = 2;
  localparam int BIT_PD0_WAKE   = 2;
  localparam int FLAG_W         = 3;
  localparam int OCDE_W         = 8;
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic [7:0] OCDE_RST = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;

  typedef enum logic [1:0]
  {
    ST_ACTIVE    = 2'b00,
    ST_SUSPEND   = 2'b01,
    ST_POWERDOWN = 2'b10,
    ST_RESUME    = 2'b11
  } usrw_state_e;

endpackage : usrw_pkg

// [usrw_timer.sv]
`timescale 1ns/1ps
module usrw_timer
#(
  parameter int CYCLES = 4
)
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic run_in,
  input  wire logic restart_in,
  output logic      done_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);

  if (CYCLES < 1)
  begin : g_bad_cycles
    $error("CYCLES must be at least one");
  end

  logic [CNT_W-1:0] count;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count    <= '0;
      done_out <= 1'b0;
    end
    else if (restart_in || !run_in)
    begin
      count    <= '0;
      done_out <= 1'b0;
    end
    else if (count == LAST)
    begin
      done_out <= 1'b1;
    end
    else
    begin
      count <= count + ONE;
    end
  end

endmodule : usrw_timer
